// ### dpc_pkg.sv
package dpc_pkg;

  // ==========================================================================
  // array geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int TOKEN_COUNT = 8;
  localparam int TOKEN_ADDR_W = 3;
  localparam logic [13:0] MAILBOX_RIGHT_ADDR = 14'h3fff;
  localparam logic [13:0] MAILBOX_LEFT_ADDR = 14'h3ffe;

  // ==========================================================================
  // timing, in ns, and the derived cycle counts at the system clock
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int SELECT_ACCESS_TIME_NS = 40;
  localparam int OUTPUT_ACCESS_TIME_NS = 40;
  localparam int FLOWTHROUGH_DELAY_NS = 80;
  localparam int DATA_SETUP_TIME_NS = 40;
  localparam int WRITE_PULSE_NS = 40;
  localparam int RECOVER_NS = 40;
  localparam int CNT_W = 8;
  localparam int SYNC_STAGES = 2;

  function automatic logic [7:0] dpc_ns_to_cyc(input int ns);
    int c;
    c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction : dpc_ns_to_cyc

  localparam int READ_WAIT_NS =
    (SELECT_ACCESS_TIME_NS > FLOWTHROUGH_DELAY_NS) ?
    SELECT_ACCESS_TIME_NS : FLOWTHROUGH_DELAY_NS;
  localparam logic [7:0] READ_CYC = dpc_ns_to_cyc(
    (READ_WAIT_NS > OUTPUT_ACCESS_TIME_NS) ?
    READ_WAIT_NS : OUTPUT_ACCESS_TIME_NS);
  localparam logic [7:0] WRITE_CYC = dpc_ns_to_cyc(
    (DATA_SETUP_TIME_NS > WRITE_PULSE_NS) ?
    DATA_SETUP_TIME_NS : WRITE_PULSE_NS);
  localparam logic [7:0] RECOVER_CYC = dpc_ns_to_cyc(RECOVER_NS);
  localparam logic [7:0] SYNC_CYC = 8'h02;

  typedef enum {
    ST_IDLE,
    ST_ACCESS,
    ST_CAPTURE,
    ST_RELEASE,
    ST_RECOVER
  } dpc_state_type;

endpackage : dpc_pkg

// ### dpc_tmr_if.sv
interface dpc_tmr_if;
  logic start;
  logic [7:0] count;
  logic done;

  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : dpc_tmr_if

// ### dpc_timer.sv
module dpc_timer
  import dpc_pkg::*;
(
  input wire logic clk,     // system clock
  input wire logic rst_n,   // async reset, active low
  dpc_tmr_if.tmr tmr        // start/count in, done out
);

  logic [7:0] cnt_reg;
  logic done_reg;

  // ==========================================================================
  // down counter, done is one pulse count+1 edges after start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else if (tmr.start) begin
      cnt_reg <= tmr.count;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (cnt_reg == 8'h01) && !tmr.start;
    end
  end

  assign tmr.done = done_reg;

endmodule : dpc_timer

// ### dpc_port_ctrl.sv
// Function
// [RULE_01] each port reads and writes any location on its own, unclocked
// [RULE_02] array is 16K words of 8 bits, reached by own address and data
// [RULE_03] master role makes contention pins outputs, slave role inputs
// [RULE_04] contention flag when this port hits a location the other uses
// [RULE_05] eight token latches, shared, apart from the memory array
// [RULE_06] each token latch owned by at most one port at a time
// [RULE_07] port idles in low power whenever its select is deasserted
// [RULE_08] write ends on read/write going high or on select deasserted
// [RULE_09] write data held valid a setup time before read/write rises
// [RULE_10] read of a location being written valid only after flowthrough
// [RULE_11] read needs output enable with select, or token select for tokens
// [RULE_12] each port has its own mailbox interrupt flag output
// [RULE_13] top word is right mailbox, next is left; writing one flags owner
// [RULE_14] reading own mailbox clears own flag; reading the other's does not
// [RULE_15] write 0 claims token, read 0 confirms, write 1 frees; bit 0 only
// [RULE_16] both selected with same address: one wins, other sees contention
module dpc_port_ctrl
  import dpc_pkg::*;
#(
  parameter bit MASTER_ROLE = 1'b1
) (
  input wire logic CLOCK,                    // system clock, 25 MHz
  input wire logic RSTN,                     // async reset, active low
  input wire logic REQ_VALID,                // user request valid
  output logic REQ_READY,                    // controller idle, takes request
  input wire logic REQ_WRITE,                // 1 write, 0 read
  input wire logic REQ_TOKEN,                // 1 token latch, 0 memory
  input wire logic [ADDR_W-1:0] REQ_ADDR,    // word or token address
  input wire logic [DATA_W-1:0] REQ_WDATA,   // write data
  output logic RSP_VALID,                    // one-cycle answer pulse
  output logic [DATA_W-1:0] RSP_RDATA,       // read data
  output logic RSP_CONTENDED,                // contention seen during access
  output logic RSP_TOKEN_WON,                // token read returned zero
  output logic MAILBOX_IRQ,                  // own mailbox flag, active high
  output logic PORT_SELECT_N,                // chip enable pin, active low
  output logic TOKEN_SELECT_N,               // token select pin, active low
  output logic READ_WRITE_N,                 // high read, low write
  output logic OUTPUT_ENABLE_N,              // output enable pin, active low
  output logic [ADDR_W-1:0] PORT_ADDR,       // address pins
  input wire logic [DATA_W-1:0] DATA_IN,     // data pins, sensed
  output logic [DATA_W-1:0] DATA_OUT,        // data pins, driven
  output logic DATA_OE,                      // high while driving data
  input wire logic CONTENTION_N,             // contention flag pin
  input wire logic MAILBOX_INT_N,            // mailbox flag pin
  output logic ROLE_MASTER                   // role strap to the device
);

  dpc_state_type state_reg;
  logic is_write_reg;
  logic is_token_reg;
  logic [DATA_W-1:0] data_meta_reg;
  logic [DATA_W-1:0] data_sync_reg;
  logic [1:0] cont_meta_reg;
  logic [1:0] int_meta_reg;
  logic contended_reg;
  logic tmr_start_reg;
  logic [7:0] tmr_count_reg;

  dpc_tmr_if tmr_bus ();

  assign tmr_bus.start = tmr_start_reg;
  assign tmr_bus.count = tmr_count_reg;

  dpc_timer u_timer (
    .clk(CLOCK),
    .rst_n(RSTN),
    .tmr(tmr_bus)
  );

  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      data_meta_reg <= 8'h00;
      data_sync_reg <= 8'h00;
      cont_meta_reg <= 2'h3;
      int_meta_reg <= 2'h3;
    end else begin
      data_meta_reg <= DATA_IN;
      data_sync_reg <= data_meta_reg;
      cont_meta_reg <= {cont_meta_reg[0], CONTENTION_N};
      int_meta_reg <= {int_meta_reg[0], MAILBOX_INT_N};
    end
  end

  // ==========================================================================
  // role strap, device drives contention pins only when master
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ROLE_MASTER <= 1'b1;
    end else begin
      ROLE_MASTER <= MASTER_ROLE; // [RULE_03]
    end
  end

  // device sets and clears its flag; we only mirror it
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      MAILBOX_IRQ <= 1'b0;
    end else begin
      MAILBOX_IRQ <= !int_meta_reg[1]; // [RULE_12] [RULE_13] [RULE_14]
    end
  end

  // contention is sticky for the length of one access
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      contended_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      contended_reg <= 1'b0;
    end else if (!cont_meta_reg[1]) begin
      contended_reg <= 1'b1; // [RULE_04] [RULE_16]
    end
  end

  // ==========================================================================
  // access sequencer
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      is_write_reg <= 1'b0;
      is_token_reg <= 1'b0;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 8'h00;
      RSP_CONTENDED <= 1'b0;
      RSP_TOKEN_WON <= 1'b0;
      PORT_SELECT_N <= 1'b1;
      TOKEN_SELECT_N <= 1'b1;
      READ_WRITE_N <= 1'b1;
      OUTPUT_ENABLE_N <= 1'b1;
      PORT_ADDR <= 14'h0000;
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
      tmr_start_reg <= 1'b0;
      tmr_count_reg <= 8'h00;
    end else begin
      tmr_start_reg <= 1'b0;
      RSP_VALID <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            is_write_reg <= REQ_WRITE;
            is_token_reg <= REQ_TOKEN;
            PORT_ADDR <= REQ_ADDR; // [RULE_01] [RULE_02]
            PORT_SELECT_N <= REQ_TOKEN; // [RULE_11]
            TOKEN_SELECT_N <= !REQ_TOKEN; // [RULE_05] [RULE_11]
            OUTPUT_ENABLE_N <= REQ_WRITE; // [RULE_11]
            READ_WRITE_N <= !REQ_WRITE;
            DATA_OE <= REQ_WRITE;
            if (REQ_TOKEN) begin
              DATA_OUT <= {DATA_W{REQ_WDATA[0]}}; // [RULE_15] [RULE_06]
            end else begin
              DATA_OUT <= REQ_WDATA;
            end
            tmr_start_reg <= 1'b1;
            tmr_count_reg <= REQ_WRITE ? WRITE_CYC : READ_CYC; // [RULE_09]
            state_reg <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (tmr_bus.done) begin
            if (is_write_reg) begin
              READ_WRITE_N <= 1'b1; // [RULE_08] data still held
              state_reg <= ST_RELEASE;
            end else begin
              // wait out the data synchroniser after flowthrough
              tmr_start_reg <= 1'b1;
              tmr_count_reg <= SYNC_CYC; // [RULE_10]
              state_reg <= ST_CAPTURE;
            end
          end
        end
        ST_CAPTURE: begin
          if (tmr_bus.done) begin
            RSP_RDATA <= data_sync_reg;
            RSP_TOKEN_WON <= is_token_reg && !data_sync_reg[0]; // [RULE_15]
            state_reg <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          PORT_SELECT_N <= 1'b1; // [RULE_07]
          TOKEN_SELECT_N <= 1'b1;
          OUTPUT_ENABLE_N <= 1'b1;
          DATA_OE <= 1'b0;
          RSP_VALID <= 1'b1;
          RSP_CONTENDED <= contended_reg || !cont_meta_reg[1];
          if (is_write_reg) begin
            RSP_TOKEN_WON <= 1'b0;
          end
          tmr_start_reg <= 1'b1;
          tmr_count_reg <= RECOVER_CYC;
          state_reg <= ST_RECOVER;
        end
        ST_RECOVER: begin
          if (tmr_bus.done) begin
            REQ_READY <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule : dpc_port_ctrl

// ### dpc_port_ctrl_sva.sv
module dpc_port_ctrl_sva
  import dpc_pkg::*;
#(
  parameter bit MASTER_ROLE = 1'b1
) (
  input wire logic CLOCK, // clock
  input wire logic RSTN, // reset
  input wire logic REQ_VALID, // request
  input wire logic REQ_READY, // idle
  input wire logic REQ_TOKEN, // token access
  input wire logic [ADDR_W-1:0] REQ_ADDR, // address in
  input wire logic RSP_VALID, // answer
  input wire logic MAILBOX_IRQ, // flag out
  input wire logic PORT_SELECT_N, // select
  input wire logic TOKEN_SELECT_N, // token select
  input wire logic READ_WRITE_N, // direction
  input wire logic OUTPUT_ENABLE_N, // output enable
  input wire logic [ADDR_W-1:0] PORT_ADDR, // address pins
  input wire logic [DATA_W-1:0] DATA_OUT, // data pins
  input wire logic DATA_OE, // data drive
  input wire logic MAILBOX_INT_N, // flag pin
  input wire logic ROLE_MASTER // strap
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // pin sequencing
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  sequence s_wr_end;
    !READ_WRITE_N ##1 READ_WRITE_N ##1
      (PORT_SELECT_N && TOKEN_SELECT_N && RSP_VALID);
  endsequence
  sequence s_rd_hold;
    !OUTPUT_ENABLE_N [*8] ##1 !OUTPUT_ENABLE_N ##1
      (OUTPUT_ENABLE_N && RSP_VALID);
  endsequence
  AST_WRITE_END: assert property (
    $fell(READ_WRITE_N) |-> ##2 s_wr_end) else $error("write end wrong");
  AST_READ_HOLD: assert property (
    $fell(OUTPUT_ENABLE_N) |-> s_rd_hold) else $error("read hold wrong");
  AST_DATA_SETUP: assert property (
    $rose(READ_WRITE_N) |-> DATA_OE && $past(DATA_OE, 2) &&
      DATA_OUT == $past(DATA_OUT, 2)) else $error("data not set up");
  AST_IDLE_OFF: assert property (
    REQ_READY |-> PORT_SELECT_N && TOKEN_SELECT_N && !DATA_OE &&
      OUTPUT_ENABLE_N) else $error("pins active while idle");
  AST_READ_PINS: assert property (
    !OUTPUT_ENABLE_N |-> READ_WRITE_N && !DATA_OE &&
      PORT_SELECT_N != TOKEN_SELECT_N) else $error("read pins wrong");
  AST_MEM_TAKE: assert property (
    REQ_VALID && REQ_READY && !REQ_TOKEN |=> !PORT_SELECT_N &&
      PORT_ADDR == $past(REQ_ADDR)) else $error("memory access wrong");
  AST_TOK_TAKE: assert property (
    REQ_VALID && REQ_READY && REQ_TOKEN |=> !TOKEN_SELECT_N &&
      PORT_SELECT_N) else $error("token access wrong");
  AST_IRQ_SET: assert property (
    $fell(MAILBOX_INT_N) |-> ##3 MAILBOX_IRQ) else $error("flag not set");
  AST_IRQ_CLR: assert property (
    $rose(MAILBOX_INT_N) |-> ##3 !MAILBOX_IRQ) else $error("flag not clear");
  AST_ROLE: assert property (
    ROLE_MASTER == MASTER_ROLE) else $error("role strap wrong");
endmodule : dpc_port_ctrl_sva

bind dpc_port_ctrl dpc_port_ctrl_sva #(.MASTER_ROLE(MASTER_ROLE)) u_sva (
  .CLOCK(CLOCK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .REQ_TOKEN(REQ_TOKEN), .REQ_ADDR(REQ_ADDR), .RSP_VALID(RSP_VALID),
  .MAILBOX_IRQ(MAILBOX_IRQ), .PORT_SELECT_N(PORT_SELECT_N),
  .TOKEN_SELECT_N(TOKEN_SELECT_N), .READ_WRITE_N(READ_WRITE_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .PORT_ADDR(PORT_ADDR),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .MAILBOX_INT_N(MAILBOX_INT_N),
  .ROLE_MASTER(ROLE_MASTER));

// ### dpc_dev_model.sv
module dpc_dev_model
  import dpc_pkg::*;
(
  input wire logic ce_n, // port select
  input wire logic sem_n, // token select
  input wire logic rw_n, // high read, low write
  input wire logic oe_n, // output enable
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic [DATA_W-1:0] din, // write data
  output logic [DATA_W-1:0] dout, // read data
  output logic busy_n, // contention flag
  output logic int_n // own mailbox flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [TOKEN_COUNT-1:0] own_l = '0;
  logic [TOKEN_COUNT-1:0] own_r = '0;
  logic oth_act = 1'b0;
  logic [ADDR_W-1:0] oth_addr = '0;
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] last = '0;
  logic rd;
  initial int_n = 1'b1;
  // ========
  // this port, seen by the host
  assign rd = !oe_n && rw_n && (!ce_n || !sem_n);
  assign val = !sem_n ? {DATA_W{~own_l[addr[2:0]]}} : mem[addr];
  always @* if (rd) last = val;
  // released bus shows the inverse of the last value
  assign dout = rd ? val : ~last;
  assign busy_n = !(oth_act && !ce_n &&
    addr == oth_addr);
  task automatic wr(input bit tok);
    if (tok && !din[0] && !own_r[addr[2:0]]) begin
      own_l[addr[2:0]] = 1'b1;
    end
    if (tok && din[0]) own_l[addr[2:0]] = 1'b0;
    if (!tok) mem[addr] = din;
  endtask : wr
  always @(posedge rw_n) if (!ce_n || !sem_n) wr(!sem_n);
  always @(posedge ce_n) if (!rw_n) wr(1'b0);
  always @(posedge sem_n) if (!rw_n) wr(1'b1);
  always @(posedge ce_n) begin
    if (rw_n && addr == MAILBOX_LEFT_ADDR) int_n = 1'b1;
  end
  // ========
  // opposite port, driven by the bench
  task automatic other_write(input logic [13:0] a, input logic [7:0] d);
    mem[a] = d;
    if (a == MAILBOX_LEFT_ADDR) int_n = 1'b0;
  endtask : other_write
  task automatic other_token(input int i, input bit take);
    own_r[i] = take && !own_l[i];
  endtask : other_token
endmodule : dpc_dev_model

// ### dpc_port_ctrl_tb.sv
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module dpc_port_ctrl_tb import dpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_token = 1'b0, req_ready, rsp_valid, rsp_cont, rsp_won, irq;
  logic ce_n, sem_n, rw_n, oe_n, data_oe, busy_n, int_n, role;
  logic [ADDR_W-1:0] req_addr = '0, port_addr, a;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_in, data_out, dev_dout;
  logic [DATA_W-1:0] ref_mem [int];
  logic [ADDR_W-1:0] qa [$];
  int bad_count = 0, n_checks = 0, seed = 32'h1237;
  always #20 clk = ~clk;
  assign data_in = data_oe ? data_out : dev_dout;
  dpc_port_ctrl u_dut (.CLOCK(clk), .RSTN(rst_n), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_TOKEN(req_token),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .RSP_CONTENDED(rsp_cont), .RSP_TOKEN_WON(rsp_won),
    .MAILBOX_IRQ(irq), .PORT_SELECT_N(ce_n), .TOKEN_SELECT_N(sem_n),
    .READ_WRITE_N(rw_n), .OUTPUT_ENABLE_N(oe_n), .PORT_ADDR(port_addr),
    .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .CONTENTION_N(busy_n), .MAILBOX_INT_N(int_n), .ROLE_MASTER(role));
  dpc_dev_model u_dev (.ce_n(ce_n), .sem_n(sem_n), .rw_n(rw_n), .oe_n(oe_n),
    .addr(port_addr), .din(data_out), .dout(dev_dout), .busy_n(busy_n),
    .int_n(int_n));
  // ========
  // shared tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic op(input bit w, input bit t, input logic [13:0] ad,
                    input logic [7:0] wd);
    for (int n = 0; req_ready !== 1'b1 || rsp_valid === 1'b1; n++) begin
      if (n > 50) bad_count++;
      if (n > 50) wrap_up();
      @(negedge clk);
    end
    req_valid = 1'b1;
    req_write = w;
    req_token = t;
    req_addr = ad;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'b0;
    if (w && !t) ref_mem[ad] = wd;
    for (int n = 0; rsp_valid !== 1'b1; n++) begin
      if (n > 50) bad_count++;
      if (n > 50) wrap_up();
      @(negedge clk);
    end
  endtask : op
  // ========
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    `CHK(req_ready, 1'b0)
    rst_n = 1'b1;
    `CHK(role, 1'b1)
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : 14'($random(seed));
      qa.push_back(a);
      op(1'b1, 1'b0, a, 8'($random(seed)));
    end
    `CHK(irq, 1'b0)
    foreach (qa[i]) begin
      op(1'b0, 1'b0, qa[i], '0);
      `CHK(rsp_rdata, ref_mem[qa[i]])
    end
    u_dev.other_write(qa[2], 8'ha5);
    ref_mem[qa[2]] = 8'ha5;
    op(1'b0, 1'b0, qa[2], '0);
    `CHK(rsp_rdata, ref_mem[qa[2]])
    u_dev.other_write(MAILBOX_LEFT_ADDR, 8'h3c);
    repeat (4) @(negedge clk);
    `CHK(irq, 1'b1)
    op(1'b0, 1'b0, MAILBOX_RIGHT_ADDR, '0);
    `CHK(irq, 1'b1)
    op(1'b0, 1'b0, MAILBOX_LEFT_ADDR, '0);
    `CHK(rsp_rdata, 8'h3c)
    repeat (4) @(negedge clk);
    `CHK(irq, 1'b0)
    u_dev.other_token(3, 1'b1);
    for (int i = 0; i < TOKEN_COUNT + 1; i++) begin
      if (i == TOKEN_COUNT) u_dev.other_token(3, 1'b0);
      a = (i == TOKEN_COUNT) ? 14'h0003 : 14'(i);
      op(1'b1, 1'b1, a, 8'($random(seed)) & 8'hfe);
      op(1'b0, 1'b1, a, '0);
      `CHK(rsp_won, a != 14'h0003 || i == TOKEN_COUNT)
      `CHK(rsp_rdata, {8{a == 14'h0003 && i != TOKEN_COUNT}})
    end
    op(1'b1, 1'b1, 14'h0005, 8'hff);
    op(1'b0, 1'b1, 14'h0005, '0);
    `CHK(rsp_won, 1'b0)
    u_dev.oth_act = 1'b1;
    u_dev.oth_addr = 14'h0abc;
    op(1'b1, 1'b0, 14'h0abc, 8'h5a);
    `CHK(rsp_cont, 1'b1)
    op(1'b0, 1'b0, 14'h0abd, '0);
    `CHK(rsp_cont, 1'b0)
    wrap_up();
  end
endmodule : dpc_port_ctrl_tb
